// ===== rtl/smq_pkg.sv
// smq_pkg: constants, states and carriers of the step mash sequencer.
// assumes a 100 MHz clock and an apb master with 32-bit data.
// Functional notes
// - two modes, stepped mashing and boiling regulator
// - knob press, two clicks mash, three clicks boil, press commits mode
// - mash lamp on in mashing, off boiling
// - exit option press leaves everything unchanged
// - mode kept in non-volatile storage
// - no sensor shows open code upstairs
// - displays alternate temperature/time, setpoint/status
// - program holds six temperature/duration pairs
// - duration below zero gives hold, stop
// - hold keeps setpoint, freezes timer
// - stop ends program, heater forced off
// - stop step never advances, restart step one
// - zero steps skipped, none left ends
// - end heats or not per policy
// - reset menu stop moves end to stop
// - hold key short holds, long stops
// - run key starts or resumes program
// - first timer starts inside band, maybe held
// - relays per step or follow beeper
// - knob trims setpoint in mashing only, press confirms, reverts
// - output lamp mirrors heater output
// - long knob press opens parameter menu
package smq_pkg;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int DEB_MS = 20;
  localparam int LONG_MS = 5000;
  localparam int REVERT_MS = 2000;
  localparam int ALT_MS = 1000;
  localparam int MINUTE_MS = 60000;
  localparam int BEEP_MS = 500;
  localparam int N_STEPS = 6;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RELAY = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STEP0 = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  localparam int CTRL_EO = 0;
  localparam int CTRL_BEO = 1;
  localparam int CTRL_BAND_LO = 8;
  localparam int RELAY_FOLLOW_LO = 16;
  localparam logic [15:0] DUR_HOLD = 16'hfffe;
  localparam logic [15:0] DUR_STOP = 16'hffff;
  localparam logic [7:0] MIN_LAST = 8'h3b;
  localparam logic [1:0] UP_TEMP = 2'h0;
  localparam logic [1:0] UP_TIME = 2'h1;
  localparam logic [1:0] UP_OPEN = 2'h2;
  typedef enum logic [2:0] {SQ_IDLE, SQ_WAIT, SQ_RUN, SQ_HOLD, SQ_STOP, SQ_END} smq_seq_t;
  typedef enum logic [2:0] {MN_OFF, MN_EXIT, MN_STOP, MN_MASH, MN_BOIL} smq_menu_t;
  typedef struct packed {
    logic db;
    logic [4:0] dbc;
    logic [12:0] held;
    logic longd;
  } smq_btn_t;
  typedef struct packed {
    logic [15:0] dur;
    logic [15:0] temp;
  } smq_step_t;
  typedef struct packed {
    logic [1:0] upper_sel;
    logic lower_status;
    logic stop_flash;
    logic adj_dot;
  } smq_disp_t;
endpackage : smq_pkg

// ===== rtl/smq_seq.sv
// smq_seq: mode selection, reset menu, step program sequencer and keys.
// assumes debounced-free raw key levels, one-cycle encoder click pulses
// and a heat demand from an external regulator, all synchronous to clk.
`timescale 1ns/1ps
module smq_seq #(
  parameter int TICK_CYC = smq_pkg::TICK_CYC,
  parameter int N_RELAY = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic knob_raw,
  input wire logic knob_cw,
  input wire logic knob_ccw,
  input wire logic key_run_raw,
  input wire logic key_hold_raw,
  input wire logic [15:0] temp_meas,
  input wire logic sensor_ok,
  input wire logic heat_demand,
  input wire logic nv_mode_in,
  output logic nv_mode_wr,
  output logic nv_mode_out,
  output logic mash_lamp,
  output logic heater,
  output logic out_lamp,
  output logic beeper,
  output logic [N_RELAY-1:0] relay,
  output smq_pkg::smq_disp_t disp,
  output logic [15:0] set_point,
  output logic [12:0] remain_min,
  output smq_pkg::smq_seq_t seq_state,
  output smq_pkg::smq_menu_t menu_state,
  output logic param_menu
);
  import smq_pkg::*;

  // tick counter is 17 bits wide, relay fields exist for two relays only
  if (TICK_CYC < 2 || TICK_CYC > 131072 || N_RELAY < 1 || N_RELAY > 2) begin : g_bad_param
    $error("smq_seq: unsupported parameter");
  end

  typedef struct packed {
    logic [16:0] tick_cnt;
    logic tick;
    smq_btn_t [2:0] btn;
    logic loaded;
    logic mash;
    smq_menu_t menu;
    smq_seq_t seq;
    logic [2:0] idx;
    logic hold_req;
    logic [12:0] remain;
    logic [15:0] min_cnt;
    logic [15:0] conf_sp;
    logic [15:0] adj_sp;
    logic adj_pend;
    logic [10:0] adj_cnt;
    logic [9:0] alt_cnt;
    logic alt;
    logic [8:0] beep_cnt;
    logic [31:0] ctrl;
    logic [31:0] relay_cfg;
    smq_step_t [N_STEPS-1:0] program_menu;
    logic [31:0] prdata;
    logic nv_wr;
    logic heater;
    logic [N_RELAY-1:0] relay;
    smq_disp_t disp;
    logic param;
  } smq_state_t;

  smq_state_t st;
  smq_state_t next_st;
  logic [2:0] short_p;
  logic [2:0] long_p;
  logic [2:0] raw_in;
  logic go;
  logic [2:0] go_from;
  logic [2:0] nz;
  logic [15:0] diff;
  logic commit;
  logic acc;
  logic [3:0] widx;

  // first programmed step at or after a slot whose duration is not zero
  function automatic logic [2:0] find_nz(input smq_step_t [N_STEPS-1:0] p, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h7;
    for (int k = N_STEPS - 1; k >= 0; k--) begin
      if (3'(k) >= from && p[k].dur != 16'h0000) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction : find_nz

  // duration edit walking below zero into hold then stop
  function automatic logic [15:0] dur_step(input logic [15:0] d, input logic up);
    logic [15:0] r;
    r = d;
    if (!up) begin
      if (d == 16'h0000) r = DUR_HOLD;
      else if (d == DUR_HOLD) r = DUR_STOP;
      else if (d == DUR_STOP) r = DUR_STOP;
      else if (d[7:0] == 8'h00) r = {d[15:8] - 8'h01, MIN_LAST};
      else r = d - 16'h0001;
    end else begin
      if (d == DUR_STOP) r = DUR_HOLD;
      else if (d == DUR_HOLD) r = 16'h0000;
      else if (d[7:0] == MIN_LAST) r = {d[15:8] + 8'h01, 8'h00};
      else r = d + 16'h0001;
    end
    return r;
  endfunction : dur_step

  assign raw_in = {key_hold_raw, key_run_raw, knob_raw};
  assign acc = psel && penable;
  assign widx = 4'((paddr - REG_STEP0) >> 2);
  assign diff = (temp_meas > st.conf_sp) ? temp_meas - st.conf_sp : st.conf_sp - temp_meas;
  assign commit = short_p[0] && (st.menu == MN_MASH || st.menu == MN_BOIL);

  always_comb begin
    next_st = st;
    short_p = 3'h0;
    long_p = 3'h0;
    go = 1'b0;
    go_from = 3'h0;
    nz = 3'h7;
    next_st.nv_wr = 1'b0;
    next_st.param = 1'b0;
    // millisecond tick for every timed behaviour
    next_st.tick = 1'b0;
    next_st.tick_cnt = st.tick_cnt + 17'h00001;
    if (st.tick_cnt == 17'(TICK_CYC - 1)) begin
      next_st.tick_cnt = 17'h00000;
      next_st.tick = 1'b1;
    end
    // mode is restored once after reset, never under the async reset
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.mash = nv_mode_in;
    end
    // debounce and short/long press detection, knob, run and hold keys
    for (int i = 0; i < 3; i++) begin
      if (st.tick) begin
        if (raw_in[i] != st.btn[i].db) begin
          next_st.btn[i].dbc = st.btn[i].dbc + 5'h01;
          if (st.btn[i].dbc == 5'(DEB_MS - 1)) begin
            next_st.btn[i].db = raw_in[i];
            next_st.btn[i].dbc = 5'h00;
            if (!raw_in[i] && !st.btn[i].longd) short_p[i] = 1'b1;
            next_st.btn[i].held = 13'h0000;
            next_st.btn[i].longd = 1'b0;
          end
        end else begin
          next_st.btn[i].dbc = 5'h00;
        end
        if (st.btn[i].db && !st.btn[i].longd) begin
          next_st.btn[i].held = st.btn[i].held + 13'h0001;
          if (st.btn[i].held == 13'(LONG_MS - 1)) begin
            long_p[i] = 1'b1;
            next_st.btn[i].longd = 1'b1;
          end
        end
      end
    end
    // long knob press hands over to the parameter menu
    if (long_p[0]) begin
      next_st.param = 1'b1;
      next_st.menu = MN_OFF;
    end
    // reset menu and provisional setpoint trim on the knob
    if (st.menu != MN_OFF) begin
      if (knob_cw && st.menu != MN_BOIL) next_st.menu = smq_menu_t'(st.menu + 3'h1);
      if (knob_ccw && st.menu != MN_EXIT) next_st.menu = smq_menu_t'(st.menu - 3'h1);
      if (short_p[0]) begin
        next_st.menu = MN_OFF;
        if (st.menu == MN_STOP) begin
          next_st.seq = SQ_STOP;
          next_st.hold_req = 1'b0;
        end
        if (st.menu == MN_MASH || st.menu == MN_BOIL) begin
          next_st.mash = (st.menu == MN_MASH);
          next_st.nv_wr = 1'b1;
        end
      end
    end else begin
      if (st.mash && (knob_cw || knob_ccw)) begin
        next_st.adj_sp = (st.adj_pend ? st.adj_sp : st.conf_sp) + (knob_cw ? 16'h0001 : 16'hffff);
        next_st.adj_pend = 1'b1;
        next_st.adj_cnt = 11'h000;
      end else if (short_p[0] && st.adj_pend) begin
        next_st.conf_sp = st.adj_sp;
        next_st.adj_pend = 1'b0;
      end else if (short_p[0]) begin
        next_st.menu = MN_EXIT;
      end else if (st.adj_pend && st.tick) begin
        next_st.adj_cnt = st.adj_cnt + 11'h001;
        if (st.adj_cnt == 11'(REVERT_MS - 1)) next_st.adj_pend = 1'b0;
      end
    end
    // program keys
    if (long_p[2]) begin
      next_st.seq = SQ_STOP;
      next_st.hold_req = 1'b0;
    end else if (short_p[2]) begin
      if (st.seq == SQ_RUN) next_st.seq = SQ_HOLD;
      if (st.seq == SQ_WAIT || st.seq == SQ_IDLE) next_st.hold_req = 1'b1;
    end else if (short_p[1]) begin
      if (st.seq == SQ_HOLD) begin
        next_st.seq = SQ_RUN;
        if (st.remain == 13'h0000) begin
          go = 1'b1;
          go_from = st.idx + 3'h1;
        end
      end else if (st.seq == SQ_IDLE || st.seq == SQ_STOP) begin
        next_st.seq = SQ_WAIT;
        next_st.idx = 3'h0;
        next_st.conf_sp = st.program_menu[0].temp;
      end
    end
    // first step starts inside the band, held if asked beforehand
    if (st.seq == SQ_WAIT && diff < {8'h00, st.ctrl[CTRL_BAND_LO +: 8]}) begin
      go = 1'b1;
      go_from = 3'h0;
      next_st.beep_cnt = 9'(BEEP_MS);
    end
    // minute countdown, frozen in hold
    if (st.seq == SQ_RUN && st.tick && st.remain != 13'h0000) begin
      next_st.min_cnt = st.min_cnt + 16'h0001;
      if (st.min_cnt == 16'(MINUTE_MS - 1)) begin
        next_st.min_cnt = 16'h0000;
        next_st.remain = st.remain - 13'h0001;
        if (st.remain == 13'h0001) begin
          go = 1'b1;
          go_from = st.idx + 3'h1;
          next_st.beep_cnt = 9'(BEEP_MS);
        end
      end
    end
    // enter the next non-zero step: hold, stop or timed; a stop in this cycle wins
    if (go && next_st.seq != SQ_STOP) begin
      nz = (go_from >= 3'(N_STEPS)) ? 3'h7 : find_nz(st.program_menu, go_from);
      next_st.min_cnt = 16'h0000;
      next_st.remain = 13'h0000;
      if (nz == 3'h7) begin
        next_st.seq = SQ_END;
      end else begin
        next_st.idx = nz;
        next_st.conf_sp = st.program_menu[nz].temp;
        next_st.adj_pend = 1'b0;
        if (st.program_menu[nz].dur == DUR_HOLD) begin
          next_st.seq = SQ_HOLD;
        end else if (st.program_menu[nz].dur == DUR_STOP) begin
          next_st.seq = SQ_STOP;
        end else begin
          // an early hold request loads the timer but starts it frozen
          next_st.seq = (st.seq == SQ_WAIT && st.hold_req) ? SQ_HOLD : SQ_RUN;
          next_st.remain = {5'h00, st.program_menu[nz].dur[15:8]} * 13'd60 + {5'h00, st.program_menu[nz].dur[7:0]};
        end
        if (st.seq == SQ_WAIT) next_st.hold_req = 1'b0;
      end
    end
    if (st.beep_cnt != 9'h000 && st.tick) next_st.beep_cnt = st.beep_cnt - 9'h001;
    // display alternation once per second
    if (st.tick) begin
      next_st.alt_cnt = st.alt_cnt + 10'h001;
      if (st.alt_cnt == 10'(ALT_MS - 1)) begin
        next_st.alt_cnt = 10'h000;
        next_st.alt = !st.alt;
      end
    end
    next_st.disp.upper_sel = !sensor_ok ? UP_OPEN :
      (st.seq == SQ_RUN && st.alt) ? UP_TIME : UP_TEMP;
    next_st.disp.lower_status = st.alt && st.seq inside {SQ_RUN, SQ_HOLD, SQ_STOP};
    next_st.disp.stop_flash = (st.seq == SQ_STOP);
    next_st.disp.adj_dot = st.adj_pend && st.alt;
    // heater gate: stop and open sensor kill it, end follows policy
    next_st.heater = heat_demand && sensor_ok && st.seq != SQ_STOP &&
      !(st.seq == SQ_END && !st.ctrl[st.mash ? CTRL_EO : CTRL_BEO]);
    for (int r = 0; r < N_RELAY; r++) begin
      next_st.relay[r] = st.relay_cfg[RELAY_FOLLOW_LO + r] ? (st.beep_cnt != 9'h000) :
        (st.relay_cfg[8 * r + 32'(st.idx)] && st.seq inside {SQ_RUN, SQ_HOLD});
    end
    // apb: read data latched in setup, zero-wait access phase
    if (psel && !penable) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL: next_st.prdata = st.ctrl;
        REG_RELAY: next_st.prdata = st.relay_cfg;
        REG_STATUS: next_st.prdata = {st.conf_sp, st.remain[7:0], st.mash, st.idx, 1'b0, st.seq};
        default: begin
          if (paddr >= REG_STEP0 && widx < 4'(N_STEPS) && paddr[1:0] == 2'h0)
            next_st.prdata = st.program_menu[widx[2:0]];
        end
      endcase
    end
    if (acc && pwrite) begin
      case (paddr)
        REG_CTRL: next_st.ctrl = pwdata;
        REG_RELAY: next_st.relay_cfg = pwdata;
        REG_CMD: begin
          if (pwdata[10:8] < 3'(N_STEPS) && pwdata[1:0] != 2'h0)
            next_st.program_menu[pwdata[10:8]].dur = dur_step(st.program_menu[pwdata[10:8]].dur, pwdata[1]);
        end
        default: begin
          if (paddr >= REG_STEP0 && widx < 4'(N_STEPS) && paddr[1:0] == 2'h0)
            next_st.program_menu[widx[2:0]] = pwdata;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.ctrl <= CTRL_RST;
      st.seq <= SQ_IDLE;
      st.menu <= MN_OFF;
    end else begin
      st <= next_st;
    end
  end

  // outputs, data from flops, handshake combinational
  assign pready = acc;
  assign pslverr = acc && !(paddr inside {REG_CTRL, REG_RELAY, REG_STATUS, REG_CMD} ||
    (paddr >= REG_STEP0 && widx < 4'(N_STEPS) && paddr[1:0] == 2'h0));
  assign prdata = st.prdata;
  assign nv_mode_wr = st.nv_wr;
  assign nv_mode_out = st.mash;
  assign mash_lamp = st.mash;
  assign heater = st.heater;
  assign out_lamp = st.heater;
  assign beeper = (st.beep_cnt != 9'h000);
  assign relay = st.relay;
  assign disp = st.disp;
  assign set_point = st.adj_pend ? st.adj_sp : st.conf_sp;
  assign remain_min = st.remain;
  assign seq_state = st.seq;
  assign menu_state = st.menu;
  assign param_menu = st.param;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_commit;
    commit ##1 1'b1;
  endsequence

  a_mode_commit: assert property (s_commit |-> nv_mode_wr && mash_lamp == ($past(st.menu) == MN_MASH))
    else $error("mode commit not applied");
  a_lamp_mode: assert property ($past(st.loaded) && $changed(mash_lamp) |-> $past(commit))
    else $error("mash lamp changed without commit");
  a_exit_nochg: assert property (st.menu == MN_EXIT && short_p[0] |=> menu_state == MN_OFF && $stable(mash_lamp)
    && $stable(seq_state))
    else $error("exit option changed state");
  a_stop_heater: assert property (seq_state == SQ_STOP |=> !heater)
    else $error("heater on in stop");
  a_stop_noadv: assert property (seq_state == SQ_STOP && !short_p[1] |=> seq_state == SQ_STOP)
    else $error("left stop without run key");
  a_sensor_open: assert property (!sensor_ok |=> disp.upper_sel == UP_OPEN && !heater)
    else $error("open sensor not shown");
  a_long_stop: assert property (long_p[2] |=> seq_state == SQ_STOP ##1 disp.stop_flash)
    else $error("long hold key did not stop");
  a_run_start: assert property (short_p[1] && seq_state == SQ_IDLE && !short_p[2] && !long_p[2]
    |=> seq_state == SQ_WAIT && st.idx == 3'h0)
    else $error("run key did not start");
  a_revert_dot: assert property (st.adj_pend && st.tick && st.adj_cnt == 11'(REVERT_MS - 1) && !knob_cw
    && !knob_ccw && !short_p[0] |=> !st.adj_pend && set_point == $past(st.conf_sp))
    else $error("setpoint trim did not revert");
  a_hold_frozen: assert property (seq_state == SQ_HOLD && $past(seq_state) == SQ_HOLD |-> $stable(remain_min))
    else $error("timer moved in hold");
endmodule : smq_seq

// ===== tb/smq_operator.sv
// smq_operator: behavioural operator at the knob and the two program keys.
// assumes the sequencer samples buttons on a tick of TICK_CYC clock cycles.
`timescale 1ns/1ps
module smq_operator #(
  parameter int TICK_CYC = 10
) (
  input wire logic clk,
  output logic knob_raw,
  output logic knob_cw,
  output logic knob_ccw,
  output logic key_run_raw,
  output logic key_hold_raw
);
  // everything released at power-up
  initial begin
    knob_raw = 1'b0;
    knob_cw = 1'b0;
    knob_ccw = 1'b0;
    key_run_raw = 1'b0;
    key_hold_raw = 1'b0;
  end

  // sel 0 knob, 1 run key, 2 hold key; released long enough to pass debounce
  task automatic press(input int sel, input int ms);
    @(posedge clk);
    knob_raw <= (sel == 0);
    key_run_raw <= (sel == 1);
    key_hold_raw <= (sel == 2);
    repeat (ms * TICK_CYC) @(posedge clk);
    knob_raw <= 1'b0;
    key_run_raw <= 1'b0;
    key_hold_raw <= 1'b0;
    repeat (30 * TICK_CYC) @(posedge clk);
  endtask : press

  // one-cycle detent pulses, spaced like a hand turning the knob
  task automatic click(input logic cw, input int n);
    repeat (n) begin
      @(posedge clk);
      knob_cw <= cw;
      knob_ccw <= !cw;
      @(posedge clk);
      knob_cw <= 1'b0;
      knob_ccw <= 1'b0;
      repeat (5 * TICK_CYC) @(posedge clk);
    end
  endtask : click
endmodule : smq_operator

// ===== tb/step_mash_sequencer_tb_top.sv
// step_mash_sequencer_tb_top: self-checking bench of the step mash sequencer.
// assumes smq_pkg and smq_seq; a short tick keeps the long key times affordable.
`timescale 1ns/1ps
module step_mash_sequencer_tb_top;
  import smq_pkg::*;
  localparam int TC = 10;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} smq_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, knob_raw, knob_cw, knob_ccw, key_run_raw, key_hold_raw;
  logic [15:0] temp_meas = 16'h0064;
  logic sensor_ok = 1'b1;
  logic heat_demand = 1'b1;
  logic nv_mode_in = 1'b1;
  logic nv_mode_wr, nv_mode_out, mash_lamp, heater, out_lamp, beeper, param_menu;
  logic [1:0] relay;
  smq_disp_t disp;
  logic [15:0] set_point;
  logic [12:0] remain_min;
  smq_seq_t seq_state;
  smq_menu_t menu_state;
  int num_errors = 0;
  int checks_done = 0;
  int wr_cnt = 0;
  int time_cnt = 0;
  int dot_cnt = 0;
  int t0;
  int d0;
  logic [31:0] rd;
  logic er;
  smq_row_t rows [6] = '{
    '{1'b1, REG_STEP0, 32'h0000_0064, 32'h0, 1'b0},
    '{1'b0, REG_STEP0, 32'h0, 32'h0000_0064, 1'b0},
    '{1'b1, REG_CTRL, 32'h0000_0300, 32'h0, 1'b0},
    '{1'b0, REG_CTRL, 32'h0, 32'h0000_0300, 1'b0},
    '{1'b1, 8'h40, 32'h1234_5678, 32'h0, 1'b1},
    '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1}};

  always #5 clk = ~clk;

  smq_seq #(.TICK_CYC(TC), .N_RELAY(2)) uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .knob_raw(knob_raw), .knob_cw(knob_cw), .knob_ccw(knob_ccw),
    .key_run_raw(key_run_raw), .key_hold_raw(key_hold_raw), .temp_meas(temp_meas),
    .sensor_ok(sensor_ok), .heat_demand(heat_demand), .nv_mode_in(nv_mode_in),
    .nv_mode_wr(nv_mode_wr), .nv_mode_out(nv_mode_out), .mash_lamp(mash_lamp), .heater(heater),
    .out_lamp(out_lamp), .beeper(beeper), .relay(relay), .disp(disp), .set_point(set_point),
    .remain_min(remain_min), .seq_state(seq_state), .menu_state(menu_state), .param_menu(param_menu));

  smq_operator #(.TICK_CYC(TC)) op (.clk(clk), .knob_raw(knob_raw), .knob_cw(knob_cw),
    .knob_ccw(knob_ccw), .key_run_raw(key_run_raw), .key_hold_raw(key_hold_raw));

  // running counts, taken mid-cycle so no edge race can miss or double a pulse
  always @(negedge clk) begin
    if (nv_mode_wr === 1'b1) wr_cnt <= wr_cnt + 1;
    if (disp.upper_sel === UP_TIME) time_cnt <= time_cnt + 1;
    if (disp.adj_dot === 1'b1) dot_cnt <= dot_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  // settle point well after the edge's updates
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : look

  // one apb transfer; no wait count assumed, the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_seq(input smq_seq_t s);
    int n;
    n = 0;
    while (seq_state !== s && n < 3000) begin
      look(1);
      n++;
    end
    // one more edge so registered outputs follow the new state
    look(1);
    chk("seq_wait", s, seq_state);
  endtask : wait_seq

  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // the long hold press and the revert wait dominate the run time
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("unexpected watchdog: expected %h, seen %h", 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    look(3);
    chk("seq_state", SQ_IDLE, seq_state);
    chk("mash_lamp", 1'b1, mash_lamp);
    apb(1'b0, REG_CTRL, 32'h0, rd, er);
    chk("ctrl_reset", CTRL_RST, rd);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk("pslverr", rows[i].err, er);
      if (!rows[i].w) chk("prdata", rows[i].exp, rd);
    end
    for (int i = 1; i < N_STEPS; i++) apb(1'b1, REG_STEP0 + 8'(4 * i), 32'h0, rd, er);
    // switch to boiling: three clicks pass exit, stop and mash options
    op.press(0, 30);
    chk("menu_state", MN_EXIT, menu_state);
    op.click(1'b1, 3);
    chk("menu_state", MN_BOIL, menu_state);
    op.press(0, 30);
    chk("mash_lamp", 1'b0, mash_lamp);
    chk("nv_mode_out", 1'b0, nv_mode_out);
    chk("nv_mode_wr", 1, wr_cnt);
    op.press(0, 30);
    op.click(1'b1, 2);
    chk("menu_state", MN_MASH, menu_state);
    op.press(0, 30);
    chk("mash_lamp", 1'b1, mash_lamp);
    // exit option leaves mode and program alone
    op.press(0, 30);
    op.press(0, 30);
    chk("menu_state", MN_OFF, menu_state);
    chk("mash_lamp", 1'b1, mash_lamp);
    chk("seq_state", SQ_IDLE, seq_state);
    sensor_ok <= 1'b0;
    look(5);
    chk("upper_sel", UP_OPEN, disp.upper_sel);
    @(posedge clk);
    sensor_ok <= 1'b1;
    // every duration zero: straight to end, heater per end policy
    op.press(1, 30);
    wait_seq(SQ_END);
    chk("seq_state", SQ_END, seq_state);
    chk("heater", 1'b0, heater);
    apb(1'b1, REG_CTRL, 32'h0000_0301, rd, er);
    look(3);
    chk("heater", 1'b1, heater);
    op.press(0, 30);
    op.click(1'b1, 1);
    chk("menu_state", MN_STOP, menu_state);
    op.press(0, 30);
    chk("seq_state", SQ_STOP, seq_state);
    chk("heater", 1'b0, heater);
    // one hour first step with relay 0 on in it
    apb(1'b1, REG_STEP0, 32'h0100_0064, rd, er);
    apb(1'b1, REG_RELAY, 32'h0002_0001, rd, er);
    op.press(1, 30);
    wait_seq(SQ_RUN);
    chk("seq_state", SQ_RUN, seq_state);
    chk("remain_min", 13'd60, remain_min);
    chk("relay", 2'b11, relay);
    chk("beeper", 1'b1, beeper);
    @(posedge clk);
    heat_demand <= 1'b0;
    look(3);
    chk("out_lamp", 1'b0, out_lamp);
    @(posedge clk);
    heat_demand <= 1'b1;
    look(3);
    chk("heater", 1'b1, heater);
    // trim without confirm reverts, stored step untouched
    t0 = time_cnt;
    d0 = dot_cnt;
    op.click(1'b1, 1);
    chk("set_point_moved", 1'b1, set_point != 16'h0064);
    look(2100 * TC);
    chk("adj_dot", 1'b1, dot_cnt > d0);
    chk("set_point", 16'h0064, set_point);
    chk("adj_dot", 1'b0, disp.adj_dot);
    chk("time_shown", 1'b1, time_cnt > t0);
    apb(1'b0, REG_STEP0, 32'h0, rd, er);
    chk("step0", 32'h0100_0064, rd);
    op.click(1'b1, 1);
    op.press(0, 30);
    chk("adj_dot", 1'b0, disp.adj_dot);
    chk("menu_state", MN_OFF, menu_state);
    apb(1'b0, REG_STATUS, 32'h0, rd, er);
    chk("conf_moved", 1'b1, rd[31:16] != 16'h0064);
    op.press(2, 30);
    chk("seq_state", SQ_HOLD, seq_state);
    chk("heater", 1'b1, heater);
    op.press(1, 30);
    chk("seq_state", SQ_RUN, seq_state);
    op.press(2, 5050);
    chk("seq_state", SQ_STOP, seq_state);
    chk("stop_flash", 1'b1, disp.stop_flash);
    chk("heater", 1'b0, heater);
    // restart far from the setpoint, ask for hold before the timer starts
    temp_meas <= 16'h0000;
    op.press(1, 30);
    chk("seq_state", SQ_WAIT, seq_state);
    op.press(2, 30);
    temp_meas <= 16'h0064;
    wait_seq(SQ_HOLD);
    chk("remain_min", 13'd60, remain_min);
    chk("beeper", 1'b1, beeper);
    op.press(1, 30);
    wait_seq(SQ_RUN);
    apb(1'b0, REG_STATUS, 32'h0, rd, er);
    chk("step_idx", 3'h0, rd[6:4]);
    chk("remain_min", 13'd60, remain_min);
    // second reset mid-run picks up the stored boiling mode
    @(posedge clk);
    sys_rst <= 1'b1;
    nv_mode_in <= 1'b0;
    look(2);
    chk("seq_state", SQ_IDLE, seq_state);
    chk("heater", 1'b0, heater);
    @(posedge clk);
    sys_rst <= 1'b0;
    look(3);
    chk("mash_lamp", 1'b0, mash_lamp);
    end_sim();
  end
endmodule : step_mash_sequencer_tb_top
